// >>> logic/asc_top.sv
`timescale 1ns/1ps
`default_nettype none
module asc_top (
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	input  wire logic [11:0] avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic [2:0]  trig_in,
	input  wire logic [3:0]  clk_src_in,
	input  wire logic        afe_done,
	input  wire logic [11:0] afe_data,
	output logic             afe_sample,
	output logic             afe_start,
	output logic      [2:0]  afe_ref,
	output logic      [3:0]  afe_chan,
	output logic             afe_conv_tick,
	output logic             conv_busy,
	output logic             irq
);
	// ----------------------------------------
	// input synchronisers
	// ----------------------------------------
	logic [19:0] sync1_r;
	logic [19:0] sync2_r;
	logic [3:0]  clk_prev_r;
	logic        done_prev_r;

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			sync1_r     <= 20'h0_0000;
			sync2_r     <= 20'h0_0000;
			clk_prev_r  <= 4'h0;
			done_prev_r <= 1'b0;
		end else begin
			sync1_r     <= {afe_data, afe_done, clk_src_in, trig_in};
			sync2_r     <= sync1_r;
			clk_prev_r  <= sync2_r[6:3];
			done_prev_r <= sync2_r[7];
		end
	end

	wire logic [2:0]  trig_s    = sync2_r[2:0];
	wire logic [3:0]  clk_s     = sync2_r[6:3];
	wire logic        done_rise = sync2_r[7] & ~done_prev_r;
	wire logic [11:0] data_s    = sync2_r[19:8];

	// ----------------------------------------
	// registers
	// ----------------------------------------
	logic [15:0] ctl0_r;
	logic [15:1] ctl1_r;
	logic [15:0] ie_r;
	logic [15:0] ifg_r;
	logic [7:0]  mctl_r [16];
	logic        ovf_r;
	logic        tovf_r;

	wire logic       conv_en    = ctl0_r[asc_pkg::CTL0_CONV_EN];
	wire logic       sc         = ctl0_r[asc_pkg::CTL0_SC];
	wire logic       ovie       = ctl0_r[asc_pkg::CTL0_OVIE];
	wire logic       tovie      = ctl0_r[asc_pkg::CTL0_TOVIE];
	wire logic [3:0] first_idx  = ctl1_r[asc_pkg::CTL1_FIRST +: 4];
	wire logic [1:0] src_sel    = ctl1_r[asc_pkg::CTL1_SRC +: 2];
	wire logic       pulse_mode = ctl1_r[asc_pkg::CTL1_PULSE];
	wire logic       invert     = ctl1_r[asc_pkg::CTL1_INV];
	wire logic [2:0] divider    = ctl1_r[asc_pkg::CTL1_DIV +: 3];
	wire logic [1:0] clk_src    = ctl1_r[asc_pkg::CTL1_CLKSRC +: 2];
	wire logic [1:0] seq_mode   = ctl1_r[asc_pkg::CTL1_SEQ +: 2];

	// ----------------------------------------
	// conversion clock select and divide
	// ----------------------------------------
	logic [2:0] div_cnt_r;

	wire logic [3:0] clk_rise  = clk_s & ~clk_prev_r;
	wire logic       src_tick  = clk_rise[clk_src];
	wire logic       conv_tick = src_tick && (div_cnt_r == divider);

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			div_cnt_r <= 3'h0;
		end else if (src_tick) begin
			div_cnt_r <= conv_tick ? 3'h0 : div_cnt_r + 3'h1;
		end
	end

	// ----------------------------------------
	// sample input and sampling signal
	// ----------------------------------------
	logic       samp_in_prev_r;
	logic       samp_prev_r;
	logic [7:0] samp_tmr_r;
	asc_pkg::asc_state_e state_r;

	wire logic [3:0] src_vec     = {trig_s, sc};
	wire logic       samp_in     = src_vec[src_sel] ^ invert;
	wire logic       samp_in_rise = samp_in & ~samp_in_prev_r;
	wire logic       tmr_on      = (samp_tmr_r != 8'h00);
	wire logic       sampling    = pulse_mode ? tmr_on : samp_in;
	wire logic       samp_rise   = sampling & ~samp_prev_r;
	wire logic       samp_fall   = ~sampling & samp_prev_r;
	wire logic       idle        = (state_r == asc_pkg::ST_IDLE);

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			samp_in_prev_r <= 1'b0;
			samp_prev_r    <= 1'b0;
			samp_tmr_r     <= 8'h00;
		end else begin
			samp_in_prev_r <= samp_in;
			samp_prev_r    <= sampling;
			if (samp_in_rise && conv_en && idle) begin
				samp_tmr_r <= asc_pkg::SAMPLE_TICKS;
			end else if (conv_tick && tmr_on) begin
				samp_tmr_r <= samp_tmr_r - 8'h01;
			end
		end
	end

	// ----------------------------------------
	// sequencer
	// ----------------------------------------
	logic       seq_active_r;
	logic [3:0] cur_idx_r;

	wire logic       start_taken = idle && conv_en && samp_rise;
	wire logic [3:0] act_idx     = seq_active_r ? cur_idx_r : first_idx;
	wire logic       conv_store  = (state_r == asc_pkg::ST_CONVERT) && done_rise;
	wire logic       cur_last    = mctl_r[cur_idx_r][asc_pkg::MCTL_LAST];
	wire logic [3:0] next_idx    = cur_idx_r + 4'h1;

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			state_r      <= asc_pkg::ST_IDLE;
			seq_active_r <= 1'b0;
			cur_idx_r    <= 4'h0;
			afe_start    <= 1'b0;
			afe_ref      <= 3'h0;
			afe_chan     <= 4'h0;
		end else begin
			afe_start <= 1'b0;
			case (state_r)
				asc_pkg::ST_IDLE: begin
					if (!conv_en) begin
						seq_active_r <= 1'b0;
					end else if (start_taken) begin
						cur_idx_r    <= act_idx;
						seq_active_r <= 1'b1;
						state_r      <= asc_pkg::ST_SAMPLE;
					end
				end
				asc_pkg::ST_SAMPLE: begin
					if (samp_fall) begin
						afe_start <= 1'b1;
						afe_ref   <= mctl_r[cur_idx_r][asc_pkg::MCTL_REF +: 3];
						afe_chan  <= mctl_r[cur_idx_r][asc_pkg::MCTL_CHAN +: 4];
						state_r   <= asc_pkg::ST_CONVERT;
					end
				end
				asc_pkg::ST_CONVERT: begin
					if (done_rise) begin
						state_r <= asc_pkg::ST_IDLE;
						case (seq_mode)
							asc_pkg::SEQ_SINGLE: begin
								seq_active_r <= 1'b0;
							end
							asc_pkg::SEQ_CHANNELS: begin
								seq_active_r <= !cur_last;
								cur_idx_r    <= next_idx;
							end
							asc_pkg::SEQ_REP_SINGLE: begin
								cur_idx_r <= cur_idx_r;
							end
							default: begin
								cur_idx_r <= cur_last ? first_idx : next_idx;
							end
						endcase
					end
				end
				default: begin
					state_r <= asc_pkg::ST_IDLE;
				end
			endcase
		end
	end

	wire logic busy = !idle || seq_active_r;

	// ----------------------------------------
	// bus decode
	// ----------------------------------------
	asc_pkg::asc_bus_e bus_r;
	logic [11:0] mem_rd;

	wire logic [9:0]  idx       = avs_address[11:2];
	wire logic        sel_ctl0  = (idx == asc_pkg::IDX_CTL0);
	wire logic        sel_ctl1  = (idx == asc_pkg::IDX_CTL1);
	wire logic        sel_ifg   = (idx == asc_pkg::IDX_IFG);
	wire logic        sel_ie    = (idx == asc_pkg::IDX_IE);
	wire logic        sel_iv    = (idx == asc_pkg::IDX_IV);
	wire logic        sel_mem   = (idx[9:5] == asc_pkg::IDX_MEM0[9:5]) && !idx[0];
	wire logic        sel_mctl  = (idx[9:4] == asc_pkg::IDX_MCTL0[9:4]);
	wire logic [3:0]  mem_ent   = idx[4:1];
	wire logic [3:0]  mctl_ent  = idx[3:0];
	wire logic        fire      = (bus_r == asc_pkg::BUS_DONE);
	wire logic        wr_fire   = fire && avs_write;
	wire logic        rd_fire   = fire && avs_read;
	wire logic [15:0] be_mask   = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
	wire logic [15:0] pending   = ifg_r & ie_r;

	logic [15:0] iv;
	always_comb begin
		iv = asc_pkg::IV_NONE;
		for (int i = 15; i >= 0; i--) begin
			if (pending[i]) begin
				iv = asc_pkg::IV_RESULT0 + 16'(2 * i);
			end
		end
		if (tovf_r && tovie) begin
			iv = asc_pkg::IV_TIME_OVF;
		end
		if (ovf_r && ovie) begin
			iv = asc_pkg::IV_OVERFLOW;
		end
	end

	wire logic [15:0] rd_val =
		sel_ctl0 ? ctl0_r :
		sel_ctl1 ? {ctl1_r, busy} :
		sel_ifg  ? ifg_r :
		sel_ie   ? ie_r :
		sel_iv   ? iv :
		sel_mem  ? {4'h0, mem_rd} :
		sel_mctl ? {8'h00, mctl_r[mctl_ent]} : 16'h0000;
	wire logic [15:0] wmerge = (avs_writedata[15:0] & be_mask) | (rd_val & ~be_mask);

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			bus_r           <= asc_pkg::BUS_IDLE;
			avs_waitrequest <= 1'b1;
			avs_readdata    <= 32'h0000_0000;
		end else begin
			case (bus_r)
				asc_pkg::BUS_IDLE: begin
					if (avs_read || avs_write) begin
						bus_r <= asc_pkg::BUS_FETCH;
					end
				end
				asc_pkg::BUS_FETCH: begin
					bus_r           <= asc_pkg::BUS_DONE;
					avs_waitrequest <= 1'b0;
					// read data stand until the next read answer
					if (avs_read) begin
						avs_readdata <= {16'h0000, rd_val};
					end
				end
				default: begin
					bus_r           <= asc_pkg::BUS_IDLE;
					avs_waitrequest <= 1'b1;
				end
			endcase
		end
	end

	// ----------------------------------------
	// result memory
	// ----------------------------------------
	wire logic        mem_we    = conv_store || (wr_fire && sel_mem);
	wire logic [3:0]  mem_waddr = conv_store ? cur_idx_r : mem_ent;
	wire logic [11:0] mem_wdata = conv_store ? data_s : wmerge[11:0];

	asc_result_mem asc_result_mem_inst (
		.core_clk  (core_clk),
		.rst_n     (rst_n),
		.wr_en     (mem_we),
		.wr_addr   (mem_waddr),
		.wr_data   (mem_wdata),
		.rd_addr   (mem_ent),
		.rd_data_r (mem_rd)
	);

	// ----------------------------------------
	// register updates and flags
	// ----------------------------------------
	wire logic [15:0] flag_set = conv_store ? (16'h0001 << cur_idx_r) : 16'h0000;
	wire logic [15:0] acc_clr  = (fire && sel_mem) ? (16'h0001 << mem_ent) : 16'h0000;
	wire logic [15:0] ifg_base = (wr_fire && sel_ifg) ? wmerge : ifg_r;
	wire logic        iv_rd    = rd_fire && sel_iv;
	wire logic        ovf_set  = conv_store && ifg_r[cur_idx_r];
	wire logic        tovf_set = (state_r == asc_pkg::ST_CONVERT) && samp_rise;

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			ctl0_r <= asc_pkg::CTL0_RST;
			ctl1_r <= asc_pkg::CTL1_RST[15:1];
			ie_r   <= asc_pkg::IE_RST;
			ifg_r  <= asc_pkg::IFG_RST;
			ovf_r  <= 1'b0;
			tovf_r <= 1'b0;
			for (int i = 0; i < 16; i++) begin
				mctl_r[i] <= asc_pkg::MCTL_RST;
			end
		end else begin
			if (wr_fire && sel_ctl0) begin
				ctl0_r <= wmerge;
			end else if (start_taken) begin
				ctl0_r[asc_pkg::CTL0_SC] <= 1'b0;
			end
			if (wr_fire && sel_ctl1) begin
				ctl1_r <= wmerge[15:1];
			end
			if (wr_fire && sel_ie) begin
				ie_r <= wmerge;
			end
			if (wr_fire && sel_mctl && !conv_en) begin
				mctl_r[mctl_ent] <= wmerge[7:0];
			end
			ifg_r  <= (ifg_base & ~acc_clr) | flag_set;
			ovf_r  <= ovf_set | (ovf_r & ~(iv_rd && avs_readdata[15:0] == asc_pkg::IV_OVERFLOW));
			tovf_r <= tovf_set | (tovf_r & ~(iv_rd && avs_readdata[15:0] == asc_pkg::IV_TIME_OVF));
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			afe_sample    <= 1'b0;
			afe_conv_tick <= 1'b0;
			conv_busy     <= 1'b0;
			irq           <= 1'b0;
		end else begin
			afe_sample    <= sampling;
			afe_conv_tick <= conv_tick;
			conv_busy     <= busy;
			irq           <= (|pending) || (ovf_r && ovie) || (tovf_r && tovie);
		end
	end
endmodule : asc_top
`default_nettype wire

// >>> logic/asc_pkg.sv
`default_nettype none
package asc_pkg;
	// ----------------------------------------
	// register indices (byte address = 4 * index)
	// ----------------------------------------
	localparam logic [9:0]  IDX_CTL0      = 10'h1A0;
	localparam logic [9:0]  IDX_CTL1      = 10'h1A2;
	localparam logic [9:0]  IDX_IFG       = 10'h1A4;
	localparam logic [9:0]  IDX_IE        = 10'h1A6;
	localparam logic [9:0]  IDX_IV        = 10'h1A8;
	localparam logic [9:0]  IDX_MEM0      = 10'h140;
	localparam logic [9:0]  IDX_MCTL0     = 10'h080;

	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int          CTL0_OVIE     = 3;
	localparam int          CTL0_TOVIE    = 2;
	localparam int          CTL0_CONV_EN  = 1;
	localparam int          CTL0_SC       = 0;
	localparam int          CTL1_FIRST    = 12;
	localparam int          CTL1_SRC      = 10;
	localparam int          CTL1_PULSE    = 9;
	localparam int          CTL1_INV      = 8;
	localparam int          CTL1_DIV      = 5;
	localparam int          CTL1_CLKSRC   = 3;
	localparam int          CTL1_SEQ      = 1;
	localparam int          CTL1_BUSY     = 0;
	localparam int          MCTL_LAST     = 7;
	localparam int          MCTL_REF      = 4;
	localparam int          MCTL_CHAN     = 0;

	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [15:0] CTL0_RST      = 16'h0000;
	localparam logic [15:0] CTL1_RST      = 16'h0000;
	localparam logic [15:0] IE_RST        = 16'h0000;
	localparam logic [15:0] IFG_RST       = 16'h0000;
	localparam logic [7:0]  MCTL_RST      = 8'h00;
	localparam logic [11:0] RES_RST       = 12'h000;

	// ----------------------------------------
	// sequence modes and vector codes
	// ----------------------------------------
	localparam logic [1:0]  SEQ_SINGLE    = 2'h0;
	localparam logic [1:0]  SEQ_CHANNELS  = 2'h1;
	localparam logic [1:0]  SEQ_REP_SINGLE = 2'h2;
	localparam logic [1:0]  SEQ_REP_CHANNELS = 2'h3;
	localparam logic [15:0] IV_NONE       = 16'h0000;
	localparam logic [15:0] IV_OVERFLOW   = 16'h0002;
	localparam logic [15:0] IV_TIME_OVF   = 16'h0004;
	localparam logic [15:0] IV_RESULT0    = 16'h0006;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam logic [7:0]  SAMPLE_TICKS  = 8'h04;

	typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_CONVERT} asc_state_e;
	typedef enum logic [1:0] {BUS_IDLE, BUS_FETCH, BUS_DONE} asc_bus_e;
endpackage : asc_pkg
`default_nettype wire

// >>> logic/asc_result_mem.sv
`timescale 1ns/1ps
`default_nettype none
module asc_result_mem (
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	input  wire logic        wr_en,
	input  wire logic [3:0]  wr_addr,
	input  wire logic [11:0] wr_data,
	input  wire logic [3:0]  rd_addr,
	output logic      [11:0] rd_data_r
);
	logic [11:0] mem_r [16];

	// contents survive reset; only the read register is cleared
	always_ff @(posedge core_clk) begin
		if (wr_en) begin
			mem_r[wr_addr] <= wr_data;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			rd_data_r <= asc_pkg::RES_RST;
		end else begin
			rd_data_r <= mem_r[rd_addr];
		end
	end
endmodule : asc_result_mem
`default_nettype wire

// >>> bench/asc_top_sva.sv
`timescale 1ns/1ps
`default_nettype none
module asc_top_sva (
	input wire logic        core_clk,
	input wire logic        rst_n,
	input wire logic [11:0] avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest,
	input wire logic        afe_sample,
	input wire logic        afe_start,
	input wire logic [2:0]  afe_ref,
	input wire logic [3:0]  afe_chan,
	input wire logic        afe_conv_tick,
	input wire logic        conv_busy,
	input wire logic        irq
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);

	wire logic rd_ans = avs_read && !avs_waitrequest;

	AST_BUS_ANSWER: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest ##1 avs_waitrequest
		##1 !avs_waitrequest) else $error("bus answer not on second edge");
	AST_WAIT_ONE: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low for more than one cycle");
	AST_RDATA_HOLD: assert property ($changed(avs_readdata) |-> rd_ans)
		else $error("read data changed outside a read answer");
	AST_UPPER_ZERO: assert property (avs_readdata[31:16] == 16'h0000)
		else $error("upper read data not zero");
	AST_RESULT_TOP: assert property (rd_ans && avs_address[11:8] == 4'h5 |-> avs_readdata[15:12] == 4'h0)
		else $error("result bits 15 to 12 not zero");
	AST_IV_FORM: assert property (rd_ans && avs_address == 12'h6A0 |->
		avs_readdata[15:6] == 10'h000 && !avs_readdata[0] && avs_readdata[5:0] <= 6'h24)
		else $error("vector code out of range");
	AST_CODES_HOLD: assert property (!afe_start |-> $stable({afe_ref, afe_chan}))
		else $error("entry codes changed without a start");
	AST_BUSY_START: assert property (afe_start |-> conv_busy ##1 conv_busy)
		else $error("busy low during conversion");
	AST_START_PULSE: assert property (afe_start |=> !afe_start && !afe_sample)
		else $error("start not a single pulse after sampling");
	AST_TICK_PULSE: assert property (afe_conv_tick |=> !afe_conv_tick)
		else $error("conversion tick longer than one cycle");

	cover property (afe_start);
	cover property ($rose(irq));
	cover property (rd_ans && avs_address == 12'h6A0 && avs_readdata != 32'h0000_0000);
endmodule : asc_top_sva

bind asc_top asc_top_sva asc_top_sva_inst (.core_clk, .rst_n, .avs_address, .avs_read, .avs_write,
	.avs_readdata, .avs_waitrequest, .afe_sample, .afe_start, .afe_ref, .afe_chan, .afe_conv_tick,
	.conv_busy, .irq);
`default_nettype wire

// >>> bench/asc_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin error_cnt++; $display("mismatch t=%0t got %h exp %h", $time, g, e); end end
module asc_top_tb;
	localparam logic [11:0] A_CTL0 = 12'h680;
	localparam logic [11:0] A_CTL1 = 12'h688;
	localparam logic [11:0] A_IFG  = 12'h690;
	localparam logic [11:0] A_IE   = 12'h698;
	localparam logic [11:0] A_IV   = 12'h6A0;
	logic        core_clk;
	logic        rst_n;
	logic [11:0] avs_address;
	logic        avs_read;
	logic        avs_write;
	logic [31:0] avs_writedata;
	logic [3:0]  avs_byteenable;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic [2:0]  trig_in;
	logic [3:0]  clk_src_in;
	logic        afe_done;
	logic [11:0] afe_data;
	logic        afe_sample;
	logic        afe_start;
	logic [2:0]  afe_ref;
	logic [3:0]  afe_chan;
	logic        afe_conv_tick;
	logic        conv_busy;
	logic        irq;
	int          error_cnt;
	int          checked;
	int          starts;
	int          exp_starts;
	logic [15:0] q;
	logic [2:0]  dv [4] = '{3'h0, 3'h3, 3'h5, 3'h7};

	asc_top asc_top_inst (.core_clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_byteenable, .avs_readdata, .avs_waitrequest, .trig_in, .clk_src_in, .afe_done, .afe_data,
		.afe_sample, .afe_start, .afe_ref, .afe_chan, .afe_conv_tick, .conv_busy, .irq);

	always #2.5 core_clk = ~core_clk;

	// candidate clocks: bit n rises every 2^(n+1) cycles
	always @(posedge core_clk) begin
		clk_src_in <= clk_src_in + 4'h1;
		if (afe_start === 1'b1)
			starts <= starts + 1;
	end

	task automatic test_done();
		$display("checks %0d errors %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : test_done

	// ----------------------------------------
	// bus and front end tasks
	// ----------------------------------------
	task automatic bus(input logic w, input logic [11:0] a, input logic [15:0] d);
		int n;
		avs_address <= a;
		avs_writedata <= {16'h0000, d};
		avs_write <= w;
		avs_read <= ~w;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 64);
		q = avs_readdata[15:0];
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge core_clk);
		if (n >= 64) begin
			error_cnt++;
			test_done();
		end
	endtask : bus

	task automatic rdc(input logic [11:0] a, input logic [15:0] e);
		bus(1'b0, a, 16'h0000);
		`CHK(q, e)
	endtask : rdc

	task automatic conv(input logic [11:0] d, input logic [2:0] r, input logic [3:0] c);
		int n;
		exp_starts++;
		n = 0;
		while (starts < exp_starts && n < 200) begin
			@(posedge core_clk);
			n++;
		end
		if (n >= 200) begin
			error_cnt++;
			test_done();
		end
		@(posedge core_clk);
		`CHK(afe_ref, r)
		`CHK(afe_chan, c)
		`CHK(conv_busy, 1'b1)
		afe_data <= d;
		repeat (4) @(posedge core_clk);
		afe_done <= 1'b1;
		repeat (8) @(posedge core_clk);
		afe_done <= 1'b0;
		@(posedge core_clk);
	endtask : conv

	task automatic gap(input int e);
		int n;
		for (int k = 0; k < 3; k++) begin
			n = 0;
			do begin
				@(posedge core_clk);
				n++;
			end while (afe_conv_tick !== 1'b1 && n < 400);
		end
		`CHK(n, e)
	endtask : gap

	initial begin
		repeat (100000) @(posedge core_clk);
		error_cnt++;
		test_done();
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		core_clk = 1'b0;
		rst_n = 1'b0;
		avs_address = 12'h000;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0000_0000;
		avs_byteenable = 4'h3;
		trig_in = 3'h0;
		clk_src_in = 4'h0;
		afe_done = 1'b0;
		afe_data = 12'h000;
		error_cnt = 0;
		checked = 0;
		starts = 0;
		exp_starts = 0;
		repeat (12) @(posedge core_clk);
		rst_n <= 1'b1;
		@(posedge core_clk);
		bus(1'b1, 12'h7FC, 16'hFFFF);
		rdc(12'h7FC, 16'h0000);
		rdc(A_CTL0, 16'h0000);
		rdc(A_CTL1, 16'h0000);
		rdc(A_IFG, 16'h0000);
		rdc(A_IE, 16'h0000);
		rdc(A_IV, 16'h0000);
		rdc(12'h20C, 16'h0000);
		for (int m = 0; m < 4; m++) begin
			bus(1'b1, A_CTL1, {4'h9, 2'h1, 1'b1, 1'b0, 3'h5, 2'h2, 2'(m), 1'b1});
			rdc(A_CTL1, {4'h9, 2'h1, 1'b1, 1'b0, 3'h5, 2'h2, 2'(m), 1'b0});
		end
		for (int s = 0; s < 4; s++) begin
			bus(1'b1, A_CTL1, {8'h00, dv[s], 2'(s), 3'h0});
			gap((2 << s) * (dv[s] + 1));
		end
		bus(1'b1, 12'h20C, 16'h00A5);
		rdc(12'h20C, 16'h00A5);
		bus(1'b1, A_IE, 16'h0008);
		bus(1'b1, A_CTL1, 16'h3000);
		bus(1'b1, A_CTL0, 16'h000B);
		conv(12'hABC, 3'h2, 4'h5);
		bus(1'b1, 12'h20C, 16'h0012);
		rdc(12'h20C, 16'h00A5);
		rdc(A_CTL0, 16'h000A);
		rdc(A_IFG, 16'h0008);
		`CHK(irq, 1'b1)
		rdc(A_IV, 16'h000C);
		bus(1'b1, A_CTL0, 16'h000B);
		conv(12'h123, 3'h2, 4'h5);
		rdc(A_IV, 16'h0002);
		rdc(A_IV, 16'h000C);
		rdc(12'h518, 16'h0123);
		rdc(A_IFG, 16'h0000);
		`CHK(irq, 1'b0)
		rdc(A_CTL1, 16'h3000);
		bus(1'b1, A_IE, 16'h0000);
		bus(1'b1, A_CTL0, 16'h000B);
		conv(12'hFFF, 3'h2, 4'h5);
		rdc(A_IFG, 16'h0008);
		rdc(A_IV, 16'h0000);
		`CHK(irq, 1'b0)
		bus(1'b1, A_IFG, 16'h0000);
		rdc(A_IFG, 16'h0000);
		rdc(12'h518, 16'h0FFF);
		bus(1'b1, A_CTL0, 16'h0008);
		bus(1'b1, 12'h238, 16'h0001);
		bus(1'b1, 12'h23C, 16'h0012);
		bus(1'b1, 12'h200, 16'h00A3);
		bus(1'b1, A_IE, 16'hC001);
		bus(1'b1, A_CTL1, 16'hE002);
		bus(1'b1, A_CTL0, 16'h000B);
		conv(12'h111, 3'h0, 4'h1);
		bus(1'b1, A_CTL0, 16'h000B);
		conv(12'h222, 3'h1, 4'h2);
		bus(1'b1, A_CTL0, 16'h000B);
		conv(12'h333, 3'h2, 4'h3);
		rdc(A_IFG, 16'hC001);
		rdc(A_IV, 16'h0006);
		rdc(A_CTL1, 16'hE002);
		rdc(12'h500, 16'h0333);
		bus(1'b1, A_CTL0, 16'h0008);
		bus(1'b1, A_CTL1, 16'h0400);
		bus(1'b1, A_CTL0, 16'h000A);
		bus(1'b1, A_CTL1, 16'h0500);
		repeat (6) @(posedge core_clk);
		`CHK(afe_sample, 1'b1)
		trig_in <= 3'h1;
		conv(12'h444, 3'h2, 4'h3);
		bus(1'b1, A_CTL0, 16'h0008);
		trig_in <= 3'h0;
		bus(1'b1, A_CTL1, 16'h0600);
		bus(1'b1, A_CTL0, 16'h000A);
		repeat (4) @(posedge core_clk);
		trig_in <= 3'h1;
		conv(12'h555, 3'h2, 4'h3);
		rdc(12'h500, 16'h0555);
		bus(1'b1, A_CTL0, 16'h0008);
		trig_in <= 3'h0;
		bus(1'b1, A_CTL1, 16'h0400);
		bus(1'b1, A_CTL0, 16'h000E);
		trig_in <= 3'h1;
		repeat (4) @(posedge core_clk);
		trig_in <= 3'h0;
		repeat (4) @(posedge core_clk);
		trig_in <= 3'h1;
		conv(12'h666, 3'h2, 4'h3);
		rdc(A_IV, 16'h0002);
		rdc(A_IV, 16'h0004);
		rdc(A_IV, 16'h0006);
		rdc(12'h500, 16'h0666);
		bus(1'b1, A_CTL0, 16'h0008);
		bus(1'b1, A_CTL1, 16'hE006);
		bus(1'b1, A_CTL0, 16'h000B);
		conv(12'h777, 3'h0, 4'h1);
		bus(1'b1, A_CTL0, 16'h000B);
		conv(12'h888, 3'h1, 4'h2);
		bus(1'b1, A_CTL0, 16'h000B);
		conv(12'h999, 3'h2, 4'h3);
		bus(1'b1, A_CTL0, 16'h000B);
		conv(12'hAAA, 3'h0, 4'h1);
		rdc(A_CTL1, 16'hE007);
		bus(1'b1, A_CTL0, 16'h0008);
		rdc(A_CTL1, 16'hE006);
		bus(1'b1, A_CTL1, 16'h3004);
		bus(1'b1, A_CTL0, 16'h000B);
		conv(12'hBBB, 3'h2, 4'h5);
		bus(1'b1, A_CTL1, 16'hE004);
		bus(1'b1, A_CTL0, 16'h000B);
		conv(12'hCCC, 3'h2, 4'h5);
		rdc(12'h518, 16'h0CCC);
		avs_byteenable <= 4'h1;
		bus(1'b1, A_IE, 16'h5A5A);
		avs_byteenable <= 4'h3;
		rdc(A_IE, 16'hC05A);
		test_done();
	end
endmodule : asc_top_tb
`default_nettype wire
